// File: design/opt_byte_if.sv
// Purpose: link between the bus front end and one write-once byte
// Assumes: single clock, wrEn is a one-cycle pulse
// Notes:   used covers the ordinary bits, keepUsed the power-on-only bits
`timescale 1ns/1ps
interface opt_byte_if;
   logic       wrEn;
   logic [7:0] wrData;
   logic [7:0] value;
   logic       used;
   logic       keepUsed;

   modport ctrl  (output wrEn, wrData, input value, used, keepUsed);
   modport store (input wrEn, wrData, output value, used, keepUsed);
endinterface

// File: design/opt_pkg.sv
// Purpose: shared constants for the write-once option register block
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   printed offsets are register indices; byte address = 4 * index
package opt_pkg;
   // register indices and byte addresses
   localparam logic [7:0]  IDX_B     = 8'h1E;
   localparam logic [7:0]  IDX_A     = 8'h1F;
   localparam logic [7:0]  IDX_STAT  = 8'h20;
   localparam logic [31:0] ADDR_B    = {22'h000000, IDX_B, 2'b00};
   localparam logic [31:0] ADDR_A    = {22'h000000, IDX_A, 2'b00};
   localparam logic [31:0] ADDR_STAT = {22'h000000, IDX_STAT, 2'b00};

   // option_register_a fields
   localparam int BIT_WDOG_DIS  = 0;
   localparam int BIT_STOP_EN   = 1;
   localparam int BIT_SHORT_REC = 2;
   localparam int BIT_TRIP      = 3;
   localparam int BIT_LVM_PWRD  = 4;
   localparam int BIT_LVM_RSTD  = 5;
   localparam int BIT_LVM_STOP  = 6;
   localparam int BIT_WDOG_RATE = 7;

   // option_register_b fields
   localparam int BIT_SCI_SRC  = 0;
   localparam int BIT_OSC_STOP = 1;
   localparam int BIT_TB_DIV   = 2;
   localparam int BIT_CAN_EN   = 3;

   // status fields
   localparam int STAT_A_USED    = 0;
   localparam int STAT_B_USED    = 1;
   localparam int STAT_TRIP_USED = 2;
   localparam int STAT_STOPPED   = 3;
   localparam int STAT_RECOVER   = 4;

   localparam logic [7:0] RESET_VAL   = 8'h00;
   localparam logic [7:0] IMPL_A      = 8'hFF;
   localparam logic [7:0] IMPL_B      = 8'h0F;
   localparam logic [7:0] KEEP_A      = 8'h08;
   localparam logic [7:0] KEEP_B      = 8'h00;

   // stop recovery, in oscillator clock cycles
   localparam logic [12:0] SHORT_REC_CYC = 13'h0020;
   localparam logic [12:0] LONG_REC_CYC  = 13'h1000;
   localparam logic [12:0] CNT_ONE       = 13'h0001;

   // extra timebase prescaler, divide by 128
   localparam logic [6:0] TB_DIV_LAST = 7'h7F;
   localparam logic [6:0] TB_DIV_ONE  = 7'h01;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_RUN     = 2'b00,
      ST_STOPPED = 2'b01,
      ST_RECOVER = 2'b11
   } stop_state_t;
endpackage

// File: design/option_regs_top.sv
// Purpose: write-once option registers on AXI4-Lite, with option decode
// Assumes: ref_clk 40 MHz; oscClkEn and tbSrcEn are one-cycle enables
// Notes:   options are plain flip-flops and are lost on any reset, except the supply trip bit, which survives rst
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// RL1: each option register takes only the first write after a reset.
// RL2: reset clears all option bits, except the supply trip bit.
// RL3: the two registers sit at consecutive indices and read at any time.
// RL4: the supply trip bit is written once after power-on reset only.
// RL5: options live in ordinary flip-flops, not in program memory.
// RL6: one bit picks a short or long stop recovery in oscillator cycles.
// RL7: bits enable the watchdog and pick its timeout period.
// RL8: bits control the low voltage monitor and its trip point.
// RL9: one bit keeps the oscillator running in stop mode.
// RL10: one bit inserts a divide-by-128 stage before the timebase clock.
// RL11: software should write both registers right after every reset.
// RL12: with stop disabled the stop instruction is an illegal opcode.
// RL13: watchdog_disable set turns the watchdog off, clear lets it run.
// RL14: writes after the single write are ignored without error.
// RL15: the write-used flag sets on the first write and clears on reset.
module option_regs_top (
   // clock and resets
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        porRst,
   // axi4-lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // core events
   input  wire logic        stopReq,
   input  wire logic        wakeReq,
   input  wire logic        oscClkEn,
   input  wire logic        tbSrcEn,
   // stop control
   output logic             stopGrant,
   output logic             illegalOpcode,
   output logic             stopMode,
   output logic             recoveryDone,
   output logic             oscRun,
   // timebase
   output logic             tbTickEn,
   // watchdog
   output logic             watchdogEnable,
   output logic             watchdogShortTimeout,
   // low voltage monitor
   output logic             lvmEnable,
   output logic             lvmResetEnable,
   output logic             supplyTripHigh,
   // other options
   output logic             sciClockBus,
   output logic             canEnable
);
   import opt_pkg::*;

   logic        anyRst;
   logic        awHeld_r;
   logic [31:0] awAddr_r;
   logic        wHeld_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   logic        bValid_r;
   logic [1:0]  bResp_r;
   logic        rValid_r;
   logic [31:0] rData_r;
   logic [1:0]  rResp_r;
   logic        wrDo;
   logic        hitA;
   logic        hitB;
   logic        arHs;
   logic [7:0]  statVal;
   logic [7:0]  optA;
   logic [7:0]  optB;

   stop_state_t state_r;
   stop_state_t state_nxt;
   logic [12:0] recCnt_r;
   logic [6:0]  tbDiv_r;

   opt_byte_if ifA ();
   opt_byte_if ifB ();

   assign anyRst = rst | porRst;

   // option storage: plain flip-flops, cleared by reset, except the trip bit, which only porRst clears
   write_once_byte #(
      .IMPL_MASK (IMPL_A),
      .KEEP_MASK (KEEP_A)
   ) u_opt_a ( // RL5
      .ref_clk (ref_clk),
      .rst     (rst),
      .porRst  (porRst),
      .port    (ifA.store)
   );

   write_once_byte #(
      .IMPL_MASK (IMPL_B),
      .KEEP_MASK (KEEP_B)
   ) u_opt_b ( // RL5
      .ref_clk (ref_clk),
      .rst     (rst),
      .porRst  (porRst),
      .port    (ifB.store)
   );

   assign optA = ifA.value;
   assign optB = ifB.value;

   // ---------------- write channel ----------------
   assign s_axi_awready = ~awHeld_r;
   assign s_axi_wready  = ~wHeld_r;
   assign wrDo          = awHeld_r & wHeld_r & ~bValid_r;
   assign hitA          = (awAddr_r == ADDR_A);
   assign hitB          = (awAddr_r == ADDR_B);

   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         awHeld_r <= 1'b0;
         awAddr_r <= 32'h00000000;
      end else if (s_axi_awvalid && !awHeld_r) begin
         awHeld_r <= 1'b1;
         awAddr_r <= s_axi_awaddr;
      end else if (wrDo) begin
         awHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         wHeld_r <= 1'b0;
         wData_r <= 32'h00000000;
         wStrb_r <= 4'h0;
      end else if (s_axi_wvalid && !wHeld_r) begin
         wHeld_r <= 1'b1;
         wData_r <= s_axi_wdata;
         wStrb_r <= s_axi_wstrb;
      end else if (wrDo) begin
         wHeld_r <= 1'b0;
      end
   end

   // the byte lane must carry the data for the write to count
   assign ifA.wrEn   = wrDo & hitA & wStrb_r[0]; // RL15
   assign ifB.wrEn   = wrDo & hitB & wStrb_r[0]; // RL15
   assign ifA.wrData = wData_r[7:0];
   assign ifB.wrData = wData_r[7:0];

   // a spent option register still answers okay
   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         bValid_r <= 1'b0;
         bResp_r  <= RESP_OKAY;
      end else if (wrDo) begin
         bValid_r <= 1'b1;
         bResp_r  <= (hitA || hitB) ? RESP_OKAY : RESP_SLVERR; // RL14
      end else if (s_axi_bready) begin
         bValid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bValid_r;
   assign s_axi_bresp  = bResp_r;

   // ---------------- read channel ----------------
   assign s_axi_arready = ~rValid_r;
   assign arHs          = s_axi_arvalid & ~rValid_r;

   always_comb begin
      statVal                 = 8'h00;
      statVal[STAT_A_USED]    = ifA.used;
      statVal[STAT_B_USED]    = ifB.used;
      statVal[STAT_TRIP_USED] = ifA.keepUsed;
      statVal[STAT_STOPPED]   = (state_r == ST_STOPPED);
      statVal[STAT_RECOVER]   = (state_r == ST_RECOVER);
   end

   // reads are never blocked by the write-once state
   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         rValid_r <= 1'b0;
         rData_r  <= 32'h00000000;
         rResp_r  <= RESP_OKAY;
      end else if (arHs) begin
         rValid_r <= 1'b1;
         rResp_r  <= RESP_OKAY;
         case (s_axi_araddr)
            ADDR_A:    rData_r <= {24'h000000, optA}; // RL3
            ADDR_B:    rData_r <= {24'h000000, optB}; // RL3
            ADDR_STAT: rData_r <= {24'h000000, statVal};
            default: begin
               rData_r <= 32'h00000000;
               rResp_r <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rValid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rValid_r;
   assign s_axi_rdata  = rData_r;
   assign s_axi_rresp  = rResp_r;

   // ---------------- stop mode sequencing ----------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (stopReq && optA[BIT_STOP_EN]) begin
               state_nxt = ST_STOPPED; // RL12
            end
         end
         ST_STOPPED: begin
            if (wakeReq) begin
               state_nxt = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            if (oscClkEn && recCnt_r == CNT_ONE) begin
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // recovery counts oscillator enables down from the chosen delay
   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         recCnt_r <= LONG_REC_CYC;
      end else if (state_r == ST_STOPPED && wakeReq) begin
         recCnt_r <= optA[BIT_SHORT_REC] ? SHORT_REC_CYC
                                         : LONG_REC_CYC; // RL6
      end else if (state_r == ST_RECOVER && oscClkEn) begin
         recCnt_r <= recCnt_r - CNT_ONE; // RL6
      end
   end

   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         stopGrant     <= 1'b0;
         illegalOpcode <= 1'b0;
         recoveryDone  <= 1'b0;
      end else begin
         stopGrant     <= (state_r == ST_RUN) & stopReq &
                          optA[BIT_STOP_EN]; // RL12
         illegalOpcode <= (state_r == ST_RUN) & stopReq &
                          ~optA[BIT_STOP_EN]; // RL12
         recoveryDone  <= (state_r == ST_RECOVER) & oscClkEn &
                          (recCnt_r == CNT_ONE); // RL6
      end
   end

   // ---------------- timebase prescaler ----------------
   // stage holds its count when bypassed, so a later enable resumes mid-way
   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         tbDiv_r  <= 7'h00;
         tbTickEn <= 1'b0;
      end else if (tbSrcEn && optB[BIT_TB_DIV]) begin
         tbDiv_r  <= tbDiv_r + TB_DIV_ONE; // RL10
         tbTickEn <= (tbDiv_r == TB_DIV_LAST); // RL10
      end else begin
         tbTickEn <= tbSrcEn; // RL10
      end
   end

   // ---------------- option decode ----------------
   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         stopMode <= 1'b0;
         oscRun   <= 1'b1;
      end else begin
         stopMode <= (state_nxt != ST_RUN);
         oscRun   <= (state_nxt != ST_STOPPED) | optB[BIT_OSC_STOP]; // RL9
      end
   end

   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         watchdogEnable       <= 1'b0;
         watchdogShortTimeout <= 1'b0;
      end else begin
         watchdogEnable       <= ~optA[BIT_WDOG_DIS]; // RL7 RL13
         watchdogShortTimeout <= optA[BIT_WDOG_RATE]; // RL7
      end
   end

   // monitor runs in stop only when its stop bit allows it
   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         lvmEnable      <= 1'b0;
         lvmResetEnable <= 1'b0;
         supplyTripHigh <= 1'b0;
      end else begin
         lvmEnable      <= ~optA[BIT_LVM_PWRD] &
                           ((state_nxt != ST_STOPPED) |
                            optA[BIT_LVM_STOP]); // RL8
         lvmResetEnable <= ~optA[BIT_LVM_RSTD]; // RL8
         supplyTripHigh <= optA[BIT_TRIP]; // RL8
      end
   end

   always_ff @(posedge ref_clk) begin
      if (anyRst) begin
         sciClockBus <= 1'b0;
         canEnable   <= 1'b0;
      end else begin
         sciClockBus <= optB[BIT_SCI_SRC];
         canEnable   <= optB[BIT_CAN_EN];
      end
   end
endmodule

// File: design/write_once_byte.sv
// Purpose: one byte of write-once option latches
// Assumes: rst and porRst synchronous, active high
// Notes:   bits in KEEP_MASK survive rst and re-arm on porRst only
`timescale 1ns/1ps
module write_once_byte #(
   parameter logic [7:0] IMPL_MASK = 8'hFF,
   parameter logic [7:0] KEEP_MASK = 8'h00
) (
   // clock and resets
   input wire logic         ref_clk,
   input wire logic         rst,
   input wire logic         porRst,
   // towards the bus front end
   opt_byte_if.store        port
);
   import opt_pkg::*;

   logic [7:0] value_r;
   logic       used_r;
   logic       keepUsed_r;
   logic [7:0] wrMask;

   // a spent write leaves its bits alone with no error
   assign wrMask = IMPL_MASK & ((used_r ? 8'h00 : ~KEEP_MASK) |
                                (keepUsed_r ? 8'h00 : KEEP_MASK)); // RL14

   always_ff @(posedge ref_clk) begin
      if (porRst) begin
         value_r <= RESET_VAL; // RL2
      end else if (rst) begin
         value_r <= value_r & KEEP_MASK; // RL2 RL4
      end else if (port.wrEn) begin
         value_r <= (value_r & ~wrMask) | (port.wrData & wrMask); // RL1
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || porRst) begin
         used_r <= 1'b0; // RL15
      end else if (port.wrEn) begin
         used_r <= 1'b1; // RL15
      end
   end

   // only power-on re-arms the power-on-only bits
   always_ff @(posedge ref_clk) begin
      if (porRst) begin
         keepUsed_r <= 1'b0; // RL4
      end else if (port.wrEn) begin
         keepUsed_r <= 1'b1; // RL15
      end
   end

   assign port.value    = value_r;
   assign port.used     = used_r;
   assign port.keepUsed = keepUsed_r;
endmodule

// File: verification/option_regs_checker.sv
// Purpose: timing checks on the bus and stop ports of option_regs_top
// Assumes: rst and porRst synchronous, active high
// Notes:   sees top ports only; bound after the module
`timescale 1ns/1ps
module option_regs_checker (
   // clock and resets
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        porRst,
   // bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // stop control
   input wire logic        stopReq,
   input wire logic        stopMode,
   input wire logic        stopGrant,
   input wire logic        illegalOpcode,
   input wire logic        recoveryDone,
   input wire logic        oscRun
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst || porRst);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence stop_ask;
      stopReq && !stopMode;
   endsequence
   write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   stop_decide_a: assert property (stop_ask |=> stopGrant ^ illegalOpcode)
      else $error("stop request not decided");
   grant_stop_a: assert property (stopGrant |-> ##[0:1] stopMode)
      else $error("granted stop not entered");
   osc_run_a: assert property (!oscRun |-> stopMode)
      else $error("oscillator off outside stop");
   recover_end_a: assert property ($fell(stopMode) |-> recoveryDone)
      else $error("stop left without recovery");
   reset_idle_a: assert property (disable iff (1'b0)
      rst |=> !s_axi_bvalid && !s_axi_rvalid)
      else $error("response pending after reset");
endmodule

bind option_regs_top option_regs_checker chk_i (.ref_clk, .rst, .porRst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .stopReq, .stopMode,
   .stopGrant, .illegalOpcode, .recoveryDone, .oscRun);

// File: verification/tb.sv
// Purpose: self-checking bench for option_regs_top
// Assumes: 40 MHz ref_clk, random data from a fixed seed
// Notes:   oscillator and timebase enables are random to vary spacing
`timescale 1ns/1ps
module tb;
   import opt_pkg::*;
   logic        ref_clk = 0, rst = 1, porRst = 1;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   logic [3:0]  s_axi_wstrb = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        stopReq = 0, wakeReq = 0, oscClkEn = 0, tbSrcEn = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, stopGrant, illegalOpcode, stopMode;
   logic        recoveryDone, oscRun, tbTickEn, watchdogEnable;
   logic        watchdogShortTimeout, lvmEnable, lvmResetEnable;
   logic        supplyTripHigh, sciClockBus, canEnable;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   logic [7:0]  va, vb, vn;
   int          errors = 0, n_checks = 0, seed = 32'h53AB;

   option_regs_top uut (.ref_clk, .rst, .porRst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stopReq,
      .wakeReq, .oscClkEn, .tbSrcEn, .stopGrant, .illegalOpcode, .stopMode,
      .recoveryDone, .oscRun, .tbTickEn, .watchdogEnable,
      .watchdogShortTimeout, .lvmEnable, .lvmResetEnable, .supplyTripHigh,
      .sciClockBus, .canEnable);

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] exp_rd(logic [7:0] v, logic [7:0] m);
      return {24'h000000, v & m};
   endfunction

   // the power-on-only bit keeps its old value after a plain reset
   function automatic logic [7:0] merge_a(logic [7:0] o, logic [7:0] n);
      return (n & ~KEEP_A) | (o & KEEP_A);
   endfunction

   task finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // offers address and data together, each released when taken
   task axi_wr(input logic [31:0] a, input logic [7:0] v);
      logic pa, pw;
      pa = 1;
      pw = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'($random(seed)), v};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (pa || pw) begin
         @(posedge ref_clk);
         if (pa && s_axi_awready) begin
            pa = 0;
            s_axi_awvalid <= 0;
         end
         if (pw && s_axi_wready) begin
            pw = 0;
            s_axi_wvalid <= 0;
         end
      end
      // late bready makes the response wait, so its hold is exercised
      repeat (2) @(posedge ref_clk);
      s_axi_bready <= 1;
      do @(posedge ref_clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask

   task axi_rd(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      // late rready makes the read data wait, so its hold is exercised
      @(posedge ref_clk);
      s_axi_rready <= 1;
      do @(posedge ref_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask

   task stop_try(input logic g, input int n, input logic osc);
      int cnt;
      logic fin;
      cnt = 0;
      fin = 0;
      stopReq <= 1;
      @(posedge ref_clk);
      stopReq <= 0;
      @(posedge ref_clk);
      chk(stopGrant, g, "grant");
      chk(illegalOpcode, !g, "illegal opcode");
      if (g) begin
         @(posedge ref_clk);
         chk(oscRun, osc, "oscillator in stop");
         wakeReq <= 1;
         @(posedge ref_clk);
         wakeReq <= 0;
         // counting stops as the pulse shows, so no late enable is counted
         for (int k = 0; k < 20000 && !fin; k++) begin
            @(posedge ref_clk);
            fin = recoveryDone;
            if (!fin && oscClkEn) cnt++;
            oscClkEn <= fin ? 1'b0 : 1'($random(seed));
         end
         chk(cnt, n, "recovery length");
         chk(stopMode, 0, "stop left");
      end
   endtask

   // with the prescaler one tick per 128 source ticks, else one each
   task tb_run(input logic div);
      int n, t;
      n = 0;
      t = 0;
      for (int k = 0; k < 603; k++) begin
         @(posedge ref_clk);
         if (tbSrcEn) n++;
         if (tbTickEn) t++;
         tbSrcEn <= (k < 600) ? 1'($random(seed)) : 1'b0;
      end
      chk(t, div ? n / 128 : n, "timebase ticks");
   endtask

   initial begin
      #1000000;
      errors++;
      $display("mismatch at %0t: timeout", $time);
      finish_test;
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 0;
      porRst <= 0;
      @(posedge ref_clk);
      axi_rd(ADDR_A);
      chk(d, exp_rd(RESET_VAL, IMPL_A), "A after power-on");
      axi_rd(ADDR_B);
      chk(d, exp_rd(RESET_VAL, IMPL_B), "B after power-on");
      chk(watchdogEnable, 1, "watchdog on");
      stop_try(0, 0, 0);
      $display("test reset done");
      va = 8'($random(seed)) | 8'h06;
      axi_wr(ADDR_A, va);
      chk(r, RESP_OKAY, "A write");
      axi_rd(ADDR_A);
      chk(d, exp_rd(va, IMPL_A), "A value");
      chk(watchdogEnable, !va[BIT_WDOG_DIS], "watchdog");
      chk(watchdogShortTimeout, va[BIT_WDOG_RATE], "rate");
      chk(lvmResetEnable, !va[BIT_LVM_RSTD], "monitor reset");
      chk(lvmEnable, !va[BIT_LVM_PWRD], "monitor power");
      chk(supplyTripHigh, va[BIT_TRIP], "trip");
      axi_wr(ADDR_A, ~va);
      chk(r, RESP_OKAY, "second write");
      axi_rd(ADDR_A);
      chk(d, exp_rd(va, IMPL_A), "A kept");
      vb = 8'($random(seed)) & 8'hF9;
      axi_wr(ADDR_B, vb);
      axi_rd(ADDR_B);
      chk(d, exp_rd(vb, IMPL_B), "B value");
      chk(canEnable, vb[BIT_CAN_EN], "can");
      chk(sciClockBus, vb[BIT_SCI_SRC], "sci");
      axi_wr(ADDR_STAT + 32'h4, va);
      chk(r, RESP_SLVERR, "unmapped write");
      axi_rd(ADDR_STAT + 32'h4);
      chk(d, 32'h00000000, "unmapped read data");
      chk(r, RESP_SLVERR, "unmapped read");
      axi_rd(ADDR_STAT);
      chk(d, 32'h00000007, "used flags");
      $display("test first writes done");
      tb_run(0);
      stop_try(1, SHORT_REC_CYC, 0);
      $display("test short stop done");
      rst <= 1;
      repeat (2) @(posedge ref_clk);
      rst <= 0;
      @(posedge ref_clk);
      axi_rd(ADDR_A);
      chk(d, exp_rd(va & KEEP_A, IMPL_A), "A after reset");
      axi_rd(ADDR_B);
      chk(d, exp_rd(RESET_VAL, IMPL_B), "B after reset");
      vn = (8'($random(seed)) & 8'hF3) | 8'h02 | (~va & KEEP_A);
      axi_wr(ADDR_A, vn);
      axi_rd(ADDR_A);
      chk(d, exp_rd(merge_a(va, vn), IMPL_A), "A rewritten");
      axi_wr(ADDR_B, 8'h06);
      tb_run(1);
      stop_try(1, LONG_REC_CYC, 1);
      $display("test plain reset done");
      porRst <= 1;
      repeat (2) @(posedge ref_clk);
      porRst <= 0;
      @(posedge ref_clk);
      axi_rd(ADDR_A);
      chk(d, exp_rd(RESET_VAL, IMPL_A), "A after power-on");
      axi_wr(ADDR_A, KEEP_A);
      axi_rd(ADDR_A);
      chk(d, exp_rd(KEEP_A, IMPL_A), "trip rearmed");
      chk(supplyTripHigh, 1, "trip high");
      $display("test power-on done");
      finish_test;
   end
endmodule
